// ===== hdl/sea_pkg.sv
package sea_pkg;
  localparam int unsigned WORD_W          = 16;
  localparam int unsigned PAGE_WORDS      = 4;
  localparam int unsigned FIFO_DEPTH_DFLT = 2;
  localparam int unsigned WORDS_DFLT      = 256;
  localparam int unsigned ADDR_W_SMALL    = 6;
  localparam int unsigned ADDR_W_LARGE    = 8;
  localparam int unsigned WORDS_SMALL     = 64;
  localparam int unsigned WORDS_MID       = 128;
  // program_cycle_time, a least time: rounded up
  localparam longint unsigned PROGRAM_CYCLE_TIME_MS = 10;
  localparam longint unsigned NS_PER_MS             = 1000000;
  localparam longint unsigned CLK_PERIOD_NS         = 8;
  localparam int unsigned PROG_CYCLES_DFLT = int'(
    (PROGRAM_CYCLE_TIME_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned PROG_CYCLES_MIN = 16;
  // synchroniser lanes
  localparam int unsigned PIN_CS   = 0;
  localparam int unsigned PIN_SCLK = 1;
  localparam int unsigned PIN_SDI  = 2;
  localparam int unsigned PIN_PRE  = 3;
  localparam int unsigned PIN_W    = 4;
  localparam int unsigned PIN_SUP  = 5;
  localparam int unsigned PIN_N    = 6;
  // opcode field and extended field
  localparam logic [1:0] OPC_READ  = 2'h2;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_PAGE  = 2'h3;
  localparam logic [1:0] EXT_ALL   = 2'h1;
  localparam logic [1:0] EXT_EN    = 2'h3;
  localparam logic [1:0] EXT_DIS   = 2'h0;
  typedef enum {OP_NONE, OP_READ, OP_WORD, OP_PAGE, OP_ALL, OP_WEN, OP_WDS,
                OP_PRRD, OP_PRW, OP_PRC, OP_PREN, OP_PRDS} sea_op_e;
  typedef enum {ST_IDLE, ST_START, ST_HDR, ST_DATA, ST_READ,
                ST_DONE} sea_state_e;
endpackage

// ===== hdl/sea_core.sv
// Function
// - array holds 256, 128 or 64 words of 16 bits.
// - read loads the given address into the read pointer.
// - word bits leave serially on sdo, paced by the serial clock.
// - pointer advances per word; stream continues while select stays high.
// - pointer past the top address wraps to zero.
// - page write of up to four words in one programming cycle.
// - fill-all programs every word with one 16-bit pattern.
// - protection register outside the array sets the guarded area.
// - once the lock bit is set, protection register changes only on nv_init_in.
// - programming timed internally, independent of the serial clock.
// - programming erases target words itself; no separate erase.
// - single write programs exactly one word at the address.
// - page program writes up to four consecutive words.
// - writes touching any guarded address program nothing.
// - after programming starts, select high shows busy/ready on sdo.
// - inputs ignored while supply is below threshold.
// - select rising with clock low starts instruction decode.
// - rising clock samples start bit, two opcode bits, then address.
// - address is 6 bits for 64 words, else 8 bits.
// - reset clears programming and leaves writes disabled.
`timescale 1ns/100ps
module sea_core #(
  parameter int unsigned WORDS       = sea_pkg::WORDS_DFLT,
  parameter int unsigned FIFO_DEPTH  = sea_pkg::FIFO_DEPTH_DFLT,
  parameter int unsigned PROG_CYCLES = sea_pkg::PROG_CYCLES_DFLT
) (
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic nv_init_in,
  input  wire logic supply_ok_in,
  input  wire logic cs_in,
  input  wire logic sclk_in,
  input  wire logic sdi_in,
  input  wire logic pre_in,
  input  wire logic write_allow_in,
  output logic      sdo_out,
  output logic      sdo_oe_n_out
);
  localparam int unsigned AW = (WORDS == sea_pkg::WORDS_SMALL) ?
    sea_pkg::ADDR_W_SMALL : sea_pkg::ADDR_W_LARGE;
  localparam int unsigned HW = AW + 2;
  localparam int unsigned DW = sea_pkg::WORD_W;
  localparam int unsigned NP = sea_pkg::PIN_N;
  localparam int unsigned FW = $clog2(FIFO_DEPTH);
  localparam int unsigned CW = $clog2(FIFO_DEPTH + 1);
  localparam int unsigned PW = $clog2(PROG_CYCLES + 1);
  localparam logic [AW-1:0] LAST = AW'(WORDS - 1);

  if (!(WORDS == sea_pkg::WORDS_SMALL || WORDS == sea_pkg::WORDS_MID ||
        WORDS == sea_pkg::WORDS_DFLT) || FIFO_DEPTH < 2 ||
      (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0 ||
      PROG_CYCLES < sea_pkg::PROG_CYCLES_MIN) begin : g_bad
    $error("sea_core: unsupported parameter set");
  end

  function automatic logic [AW-1:0] step(input logic [AW-1:0] a,
                                         input logic [2:0]    k);
    logic [AW:0] s;
    s = {1'h0, a} + (AW+1)'(k);
    return (s > (AW+1)'(LAST)) ? AW'(s - (AW+1)'(WORDS)) : s[AW-1:0];
  endfunction

  function automatic sea_pkg::sea_op_e decode(input logic          p,
                                              input logic [HW-1:0] h);
    logic [1:0] o;
    logic [1:0] x;
    o = h[HW-1 -: 2];
    x = h[AW-1 -: 2];
    decode = sea_pkg::OP_NONE;
    if (o == sea_pkg::OPC_READ)
      decode = p ? sea_pkg::OP_PRRD : sea_pkg::OP_READ;
    else if (o == sea_pkg::OPC_WRITE)
      decode = p ? sea_pkg::OP_PRW : sea_pkg::OP_WORD;
    else if (o == sea_pkg::OPC_PAGE)
      decode = !p ? sea_pkg::OP_PAGE :
               (&h[AW-1:0]) ? sea_pkg::OP_PRC : sea_pkg::OP_NONE;
    else if (x == sea_pkg::EXT_ALL && !p)
      decode = sea_pkg::OP_ALL;
    else if (x == sea_pkg::EXT_EN)
      decode = p ? sea_pkg::OP_PREN : sea_pkg::OP_WEN;
    else if (x == sea_pkg::EXT_DIS && !p)
      decode = sea_pkg::OP_WDS;
    else if (x == sea_pkg::EXT_DIS && h[AW-1:0] == '0)
      decode = sea_pkg::OP_PRDS;
  endfunction

  // pin synchroniser: three flops, change taken once stages 2 and 3 agree
  logic [NP-1:0] pins;
  logic [NP-1:0] s1;
  logic [NP-1:0] s2;
  logic [NP-1:0] s3;
  logic [NP-1:0] filt;
  logic [NP-1:0] filt_d;
  logic [NP-1:0] next_filt;
  assign pins[sea_pkg::PIN_CS]   = cs_in;
  assign pins[sea_pkg::PIN_SCLK] = sclk_in;
  assign pins[sea_pkg::PIN_SDI]  = sdi_in;
  assign pins[sea_pkg::PIN_PRE]  = pre_in;
  assign pins[sea_pkg::PIN_W]    = write_allow_in;
  assign pins[sea_pkg::PIN_SUP]  = supply_ok_in;

  always_comb begin
    next_filt = filt;
    for (int i = 0; i < NP; i++) begin
      if (s2[i] == s3[i])
        next_filt[i] = s3[i];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s1     <= '0;
      s2     <= '0;
      s3     <= '0;
      filt   <= '0;
      filt_d <= '0;
    end else begin
      s1     <= pins;
      s2     <= s1;
      s3     <= s2;
      filt   <= next_filt;
      filt_d <= filt;
    end
  end

  logic cs;
  logic sdi;
  logic pre;
  logic wpin;
  logic sup;
  logic sclk_rise;
  logic cs_rise;
  logic cs_fall;
  assign cs        = filt[sea_pkg::PIN_CS];
  assign sdi       = filt[sea_pkg::PIN_SDI];
  assign pre       = filt[sea_pkg::PIN_PRE];
  assign wpin      = filt[sea_pkg::PIN_W];
  assign sup       = filt[sea_pkg::PIN_SUP];
  assign sclk_rise = filt[sea_pkg::PIN_SCLK] & ~filt_d[sea_pkg::PIN_SCLK];
  assign cs_rise   = cs & ~filt_d[sea_pkg::PIN_CS];
  assign cs_fall   = ~cs & filt_d[sea_pkg::PIN_CS];

  // engine state
  sea_pkg::sea_state_e st, next_st;
  sea_pkg::sea_op_e    op, next_op;
  logic [HW-1:0]       hdr, next_hdr;
  logic [3:0]          hcnt, next_hcnt;
  logic [DW-1:0]       dsh, next_dsh;
  logic [3:0]          bcnt, next_bcnt;
  logic [2:0]          wcnt, next_wcnt;
  logic [DW-1:0]       dbuf [sea_pkg::PAGE_WORDS];
  logic [DW-1:0]       next_dbuf [sea_pkg::PAGE_WORDS];
  logic                wr_en, next_wr_en;
  logic                pr_en, next_pr_en;
  logic                show_st, next_show;
  logic [PW-1:0]       prog_cnt, next_prog;
  logic [AW-1:0]       rd_ptr, next_ptr;
  logic [DW-1:0]       sh, next_sh;
  logic [4:0]          sh_cnt, next_shc;
  logic                sdo, next_sdo;
  logic                oe_n, next_oe_n;
  logic                push;
  logic                pop;
  logic                hit;
  logic                busy;
  // nonvolatile state
  logic [DW-1:0]       mem [WORDS];
  logic [DW-1:0]       next_mem [WORDS];
  logic [AW-1:0]       prot_reg, next_prot;
  logic                prot_free, next_free;
  logic                lock, next_lock;
  // read buffer
  logic [DW-1:0]       fmem [FIFO_DEPTH];
  logic [DW-1:0]       next_fmem [FIFO_DEPTH];
  logic [FW-1:0]       fwi, next_fwi;
  logic [FW-1:0]       fri, next_fri;
  logic [CW-1:0]       fcnt, next_fcnt;
  logic                f_rdy;
  logic                f_val;

  assign busy    = prog_cnt != '0;
  assign f_rdy   = fcnt != CW'(FIFO_DEPTH);
  assign f_val   = fcnt != '0;
  assign sdo_out      = sdo;
  assign sdo_oe_n_out = oe_n;

  // guarded-area check over every target word
  always_comb begin
    hit = 1'h0;
    for (int i = 0; i < sea_pkg::PAGE_WORDS; i++) begin
      if (3'(i) < wcnt && !prot_free &&
          step(hdr[AW-1:0], 3'(i)) >= prot_reg)
        hit = 1'h1;
    end
  end

  always_comb begin
    next_st = st;
    next_op = op;
    next_hdr = hdr;
    next_hcnt = hcnt;
    next_dsh = dsh;
    next_bcnt = bcnt;
    next_wcnt = wcnt;
    next_dbuf = dbuf;
    next_wr_en = wr_en;
    next_pr_en = pr_en;
    next_show = show_st;
    next_ptr = rd_ptr;
    next_sh = sh;
    next_shc = sh_cnt;
    next_sdo = sdo;
    next_oe_n = ~cs;
    push = 1'h0;
    pop = 1'h0;
    next_prog = busy ? prog_cnt - 1'h1 : prog_cnt;
    if (!sup) begin
      next_st = sea_pkg::ST_IDLE;
      next_wr_en = 1'h0;
      next_pr_en = 1'h0;
      next_oe_n = 1'h1;
    end else if (!cs) begin
      next_st = sea_pkg::ST_IDLE;
      if (cs_fall && (st == sea_pkg::ST_DONE || (st == sea_pkg::ST_DATA &&
          bcnt == '0 && wcnt != '0))) begin
        if (op == sea_pkg::OP_WEN && wpin)
          next_wr_en = 1'h1;
        if (op == sea_pkg::OP_WDS)
          next_wr_en = 1'h0;
        if (op == sea_pkg::OP_PREN && wr_en && wpin && pre)
          next_pr_en = 1'h1;
        if (op inside {sea_pkg::OP_PRW, sea_pkg::OP_PRC, sea_pkg::OP_PRDS})
          next_pr_en = 1'h0;
        // page and word share one timed cycle
        if ((wr_en && wpin && !hit &&
             op inside {sea_pkg::OP_WORD, sea_pkg::OP_PAGE}) ||
            (wr_en && wpin && prot_free && op == sea_pkg::OP_ALL) ||
            (wr_en && wpin && pr_en && pre && !lock &&
             op inside {sea_pkg::OP_PRW, sea_pkg::OP_PRC,
                        sea_pkg::OP_PRDS})) begin
          next_prog = PW'(PROG_CYCLES);
          next_show = 1'h1;
        end
      end
    end else begin
      unique case (st)
        sea_pkg::ST_IDLE: begin
          if (cs_rise && !filt[sea_pkg::PIN_SCLK])
            next_st = sea_pkg::ST_START;
        end
        sea_pkg::ST_START: begin
          if (show_st)
            next_sdo = ~busy;
          // first one is the start bit
          if (sclk_rise && sdi && !busy) begin
            next_st = sea_pkg::ST_HDR;
            next_hcnt = '0;
            next_show = 1'h0;
          end
        end
        sea_pkg::ST_HDR: begin
          if (sclk_rise) begin
            next_hdr = {hdr[HW-2:0], sdi};
            next_hcnt = hcnt + 1'h1;
            if (hcnt == 4'(HW - 1)) begin
              next_op = decode(pre, next_hdr);
              next_st = sea_pkg::ST_DONE;
              next_bcnt = '0;
              next_wcnt = '0;
              next_sdo = 1'h0;
              next_shc = '0;
              if (next_op inside {sea_pkg::OP_WORD, sea_pkg::OP_PAGE,
                                  sea_pkg::OP_ALL})
                next_st = sea_pkg::ST_DATA;
              if (next_op == sea_pkg::OP_READ) begin
                next_st = sea_pkg::ST_READ;
                next_ptr = next_hdr[AW-1:0];
              end
              if (next_op == sea_pkg::OP_PRRD) begin
                next_st = sea_pkg::ST_READ;
                next_sh = '0;
                next_sh[DW-1 -: AW+1] = {prot_reg, prot_free};
                next_shc = 5'(AW + 1);
              end
            end
          end
        end
        sea_pkg::ST_DATA: begin
          // extra bits past the last allowed word are dropped
          if (sclk_rise && wcnt != ((op == sea_pkg::OP_PAGE) ?
              3'(sea_pkg::PAGE_WORDS) : 3'h1)) begin
            next_dsh = {dsh[DW-2:0], sdi};
            next_bcnt = bcnt + 1'h1;
            if (bcnt == 4'hf) begin
              next_dbuf[wcnt[1:0]] = next_dsh;
              next_wcnt = wcnt + 1'h1;
            end
          end
        end
        sea_pkg::ST_READ: begin
          // prefetch and advance while the buffer has room
          if (op == sea_pkg::OP_READ && f_rdy) begin
            push = 1'h1;
            next_ptr = step(rd_ptr, 3'h1);
          end
          // one bit per serial clock rise
          if (sclk_rise) begin
            if (sh_cnt != '0) begin
              next_sdo = sh[DW-1];
              next_sh = {sh[DW-2:0], 1'h0};
              next_shc = sh_cnt - 1'h1;
            end else if (op == sea_pkg::OP_READ && f_val) begin
              pop = 1'h1;
              next_sdo = fmem[fri][DW-1];
              next_sh = {fmem[fri][DW-2:0], 1'h0};
              next_shc = 5'(DW - 1);
            end else begin
              next_sdo = 1'h0;
            end
          end
        end
        sea_pkg::ST_DONE: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    // reset drops programming and write enable
    if (rst_in) begin
      st <= sea_pkg::ST_IDLE;
      op <= sea_pkg::OP_NONE;
      hdr <= '0;
      hcnt <= '0;
      dsh <= '0;
      bcnt <= '0;
      wcnt <= '0;
      dbuf <= '{default: '0};
      wr_en <= 1'h0;
      pr_en <= 1'h0;
      show_st <= 1'h0;
      prog_cnt <= '0;
      rd_ptr <= '0;
      sh <= '0;
      sh_cnt <= '0;
      sdo <= 1'h0;
      oe_n <= 1'h1;
    end else begin
      st <= next_st;
      op <= next_op;
      hdr <= next_hdr;
      hcnt <= next_hcnt;
      dsh <= next_dsh;
      bcnt <= next_bcnt;
      wcnt <= next_wcnt;
      dbuf <= next_dbuf;
      wr_en <= next_wr_en;
      pr_en <= next_pr_en;
      show_st <= next_show;
      prog_cnt <= next_prog;
      rd_ptr <= next_ptr;
      sh <= next_sh;
      sh_cnt <= next_shc;
      sdo <= next_sdo;
      oe_n <= next_oe_n;
    end
  end

  // array commits at the end of the cycle; an abort by reset leaves it intact
  always_comb begin
    next_mem = mem;
    next_prot = prot_reg;
    next_free = prot_free;
    next_lock = lock;
    if (prog_cnt == PW'(1)) begin
      if (op == sea_pkg::OP_ALL)
        next_mem = '{default: dbuf[0]};
      for (int i = 0; i < sea_pkg::PAGE_WORDS; i++) begin
        if (op inside {sea_pkg::OP_WORD, sea_pkg::OP_PAGE} && 3'(i) < wcnt)
          next_mem[step(hdr[AW-1:0], 3'(i))] = dbuf[i];
      end
      // guarded area from this address up
      if (op == sea_pkg::OP_PRW) begin
        next_prot = hdr[AW-1:0];
        next_free = 1'h0;
      end
      if (op == sea_pkg::OP_PRC) begin
        next_prot = '1;
        next_free = 1'h1;
      end
      if (op == sea_pkg::OP_PRDS)
        next_lock = 1'h1;
    end
  end

  always_ff @(posedge mclk_in) begin
    mem <= next_mem;
    if (nv_init_in) begin
      prot_reg <= '1;
      prot_free <= 1'h1;
      lock <= 1'h0;
    end else begin
      prot_reg <= next_prot;
      prot_free <= next_free;
      lock <= next_lock;
    end
  end

  // read buffer: stalls the prefetch when full
  always_comb begin
    next_fmem = fmem;
    next_fwi = fwi;
    next_fri = fri;
    if (push) begin
      next_fmem[fwi] = mem[rd_ptr];
      next_fwi = fwi + 1'h1;
    end
    if (pop)
      next_fri = fri + 1'h1;
    next_fcnt = fcnt + CW'(push) - CW'(pop);
    if (st != sea_pkg::ST_READ || !cs) begin
      next_fwi = '0;
      next_fri = '0;
      next_fcnt = '0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      fmem <= '{default: '0};
      fwi <= '0;
      fri <= '0;
      fcnt <= '0;
    end else begin
      fmem <= next_fmem;
      fwi <= next_fwi;
      fri <= next_fri;
      fcnt <= next_fcnt;
    end
  end

  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  ptr_step_a: assert property (
    push && rd_ptr != LAST |=> rd_ptr == $past(rd_ptr) + 1'h1)
    else $error("read pointer did not advance");
  ptr_wrap_a: assert property (
    push && rd_ptr == LAST |=> rd_ptr == '0)
    else $error("read pointer did not wrap");
  bit_out_a: assert property (
    st == sea_pkg::ST_READ && cs && sup && sclk_rise && sh_cnt != '0
    |=> sdo_out == $past(sh[DW-1]))
    else $error("wrong serial output bit");
  guard_block_a: assert property (
    cs_fall && sup && st == sea_pkg::ST_DATA && hit |=> !busy)
    else $error("guarded write started");
  cut_short_a: assert property (
    cs_fall && st == sea_pkg::ST_DATA && bcnt != '0 && !busy |=> !busy)
    else $error("partial instruction executed");
  prog_hold_a: assert property (
    $rose(busy) |-> busy [*8])
    else $error("programming cycle ended early");
  status_low_a: assert property (
    st == sea_pkg::ST_START && show_st && cs && sup && prog_cnt > PW'(1)
    |=> !sdo_out && !sdo_oe_n_out)
    else $error("busy not shown low");
  lock_keep_a: assert property (
    disable iff (rst_in || nv_init_in) lock |=> $stable(prot_reg))
    else $error("locked protection register changed");
  reset_wds_a: assert property (
    $fell(rst_in) |-> !wr_en && !busy)
    else $error("reset left writes enabled");
endmodule

// ===== testbench/sea_host.sv
`timescale 1ns/100ps
module sea_host (
  output logic      cs_out,
  output logic      sclk_out,
  output logic      sdi_out,
  output logic      pre_out,
  output logic      wal_out,
  input  wire logic sdo_in
);
  initial begin
    cs_out   = 1'b0;
    sclk_out = 1'b0;
    sdi_out  = 1'b0;
    pre_out  = 1'b0;
    wal_out  = 1'b1;
  end
  // write-allow pin level for the following instructions
  task automatic set_allow(input logic v);
    wal_out <= v;
    #80;
  endtask
  task automatic open_frame(input logic pre);
    pre_out <= pre;
    #40;
    cs_out <= 1'b1;
    #80;
  endtask
  task automatic cyc(input logic d, output logic q);
    sdi_out <= d;
    #31;
    sclk_out <= 1'b1;
    #62.5;
    sclk_out <= 1'b0;
    #31.5;
    q = sdo_in;
  endtask
  // idle data flipped so a stale level is never mistaken for data
  task automatic close_frame();
    sdi_out <= ~sdi_out;
    cs_out  <= 1'b0;
    #200;
  endtask
  task automatic send_hdr(input logic [1:0] op, input logic [7:0] a);
    logic        q;
    logic [10:0] v;
    v = {1'b1, op, a};
    for (int i = 10; i >= 0; i--) cyc(v[i], q);
  endtask
  task automatic send_word(input logic [15:0] w);
    logic q;
    for (int i = 15; i >= 0; i--) cyc(w[i], q);
  endtask
  task automatic recv_word(output logic [15:0] w);
    for (int i = 15; i >= 0; i--) cyc(i[0], w[i]);
  endtask
  task automatic await_ready(output logic busy, output logic rdy,
                             output int n);
    logic q;
    cs_out <= 1'b1;
    #80;
    busy = sdo_in;
    n = 0;
    q = 1'b0;
    while (q !== 1'b1 && n < 40) begin
      cyc(1'b0, q);
      n++;
    end
    rdy = q;
    close_frame();
  endtask
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
  localparam int unsigned PROG_CYC = 200;
  localparam logic [15:0] FILL     = 16'ha5c3;
  logic mclk;
  logic rst;
  logic nv_init;
  logic supply_ok;
  logic cs;
  logic sclk;
  logic sdi;
  logic pre;
  logic wal;
  logic sdo;
  logic sdo_oe_n;
  logic sdo_pin;
  int   error_cnt;
  int   total_checks;

  sea_core #(.PROG_CYCLES(PROG_CYC)) sea_core_i (
    .mclk_in(mclk), .rst_in(rst), .nv_init_in(nv_init),
    .supply_ok_in(supply_ok), .cs_in(cs), .sclk_in(sclk), .sdi_in(sdi),
    .pre_in(pre), .write_allow_in(wal), .sdo_out(sdo),
    .sdo_oe_n_out(sdo_oe_n));
  sea_host sea_host_i (
    .cs_out(cs), .sclk_out(sclk), .sdi_out(sdi), .pre_out(pre),
    .wal_out(wal), .sdo_in(sdo_pin));
  // released pin shows the inverse, so a stale level is never read as data
  assign sdo_pin = sdo_oe_n ? ~sdo : sdo;

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic p, input logic [1:0] op,
                     input logic [7:0] a);
    sea_host_i.open_frame(p);
    sea_host_i.send_hdr(op, a);
    sea_host_i.close_frame();
  endtask
  task automatic wr(input logic [1:0] op, input logic [7:0] a,
                    input logic [15:0] d);
    sea_host_i.open_frame(1'b0);
    sea_host_i.send_hdr(op, a);
    sea_host_i.send_word(d);
    sea_host_i.close_frame();
  endtask
  task automatic wait_prog();
    logic b;
    logic r;
    int   n;
    sea_host_i.await_ready(b, r, n);
    check(b, 1'b0);
    check(r, 1'b1);
    check(n >= 8 && n < 40, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp[$]);
    logic [15:0] w;
    sea_host_i.open_frame(1'b0);
    check(sdo_oe_n, 1'b0);
    sea_host_i.send_hdr(sea_pkg::OPC_READ, a);
    foreach (exp[i]) begin
      sea_host_i.recv_word(w);
      check(w, exp[i]);
    end
    sea_host_i.close_frame();
  endtask
  task automatic prot_rd(input logic [15:0] exp);
    logic [15:0] w;
    sea_host_i.open_frame(1'b1);
    sea_host_i.send_hdr(sea_pkg::OPC_READ, 8'h00);
    sea_host_i.recv_word(w);
    sea_host_i.close_frame();
    check(w, exp);
  endtask

  task automatic t_reset();
    #1;
    check(sdo, 1'b0);
    check(sdo_oe_n, 1'b1);
  endtask
  task automatic t_fill();
    cmd(1'b0, 2'h0, {sea_pkg::EXT_EN, 6'h00});
    wr(2'h0, {sea_pkg::EXT_ALL, 6'h00}, FILL);
    wait_prog();
    rd(8'h00, {FILL, FILL});
  endtask
  task automatic t_page();
    sea_host_i.open_frame(1'b0);
    sea_host_i.send_hdr(sea_pkg::OPC_PAGE, 8'hfe);
    for (int i = 0; i < 4; i++) sea_host_i.send_word(16'h1000 + 16'(i));
    sea_host_i.close_frame();
    wait_prog();
    wr(sea_pkg::OPC_WRITE, 8'h02, 16'h1234);
    wait_prog();
    rd(8'hfd, {FILL, 16'h1000, 16'h1001});
    rd(8'h00, {16'h1002, 16'h1003, 16'h1234, FILL});
    rd(8'hfe, {16'h1000, 16'h1001, 16'h1002});
  endtask
  task automatic t_protect();
    cmd(1'b1, 2'h0, {sea_pkg::EXT_EN, 6'h00});
    cmd(1'b1, sea_pkg::OPC_WRITE, 8'h80);
    wait_prog();
    wr(sea_pkg::OPC_WRITE, 8'h80, 16'hdead);
    wr(sea_pkg::OPC_WRITE, 8'h7f, 16'hbeef);
    wait_prog();
    sea_host_i.open_frame(1'b0);
    sea_host_i.send_hdr(sea_pkg::OPC_PAGE, 8'h7d);
    for (int i = 0; i < 4; i++) sea_host_i.send_word(16'h0f0f);
    sea_host_i.close_frame();
    wr(2'h0, {sea_pkg::EXT_ALL, 6'h00}, 16'h0000);
    rd(8'h7d, {FILL, FILL, 16'hbeef, FILL});
    prot_rd(16'h8000);
  endtask
  task automatic t_lock();
    logic b;
    logic r;
    int   n;
    cmd(1'b1, 2'h0, {sea_pkg::EXT_EN, 6'h00});
    cmd(1'b1, 2'h0, 8'h00);
    wait_prog();
    cmd(1'b1, 2'h0, {sea_pkg::EXT_EN, 6'h00});
    cmd(1'b1, sea_pkg::OPC_PAGE, 8'hff);
    sea_host_i.await_ready(b, r, n);
    check(r, 1'b0);
    prot_rd(16'h8000);
  endtask
  task automatic t_abort();
    logic q;
    sea_host_i.open_frame(1'b0);
    sea_host_i.send_hdr(sea_pkg::OPC_WRITE, 8'h10);
    for (int i = 0; i < 8; i++) sea_host_i.cyc(1'b1, q);
    sea_host_i.close_frame();
    rd(8'h10, {FILL});
  endtask
  task automatic t_wds();
    cmd(1'b0, 2'h0, {sea_pkg::EXT_DIS, 6'h00});
    wr(sea_pkg::OPC_WRITE, 8'h20, 16'h7777);
    rd(8'h20, {FILL});
  endtask
  task automatic t_supply();
    @(posedge mclk) supply_ok <= 1'b0;
    cmd(1'b0, 2'h0, {sea_pkg::EXT_EN, 6'h00});
    sea_host_i.open_frame(1'b0);
    check(sdo_oe_n, 1'b1);
    sea_host_i.send_hdr(sea_pkg::OPC_WRITE, 8'h12);
    sea_host_i.send_word(16'h5555);
    sea_host_i.close_frame();
    @(posedge mclk) supply_ok <= 1'b1;
    #200;
    rd(8'h12, {FILL});
  endtask
  // write-allow pin gates both the enable and the write itself
  task automatic t_allow();
    sea_host_i.set_allow(1'b0);
    cmd(1'b0, 2'h0, {sea_pkg::EXT_EN, 6'h00});
    sea_host_i.set_allow(1'b1);
    wr(sea_pkg::OPC_WRITE, 8'h30, 16'h3030);
    rd(8'h30, {FILL});
    cmd(1'b0, 2'h0, {sea_pkg::EXT_EN, 6'h00});
    sea_host_i.set_allow(1'b0);
    wr(sea_pkg::OPC_WRITE, 8'h31, 16'h3131);
    sea_host_i.set_allow(1'b1);
    rd(8'h31, {FILL});
    wr(sea_pkg::OPC_WRITE, 8'h31, 16'h3131);
    wait_prog();
    rd(8'h31, {16'h3131});
  endtask
  // reset in mid programming aborts it and disables writes
  task automatic t_rst_mid();
    cmd(1'b0, 2'h0, {sea_pkg::EXT_EN, 6'h00});
    wr(sea_pkg::OPC_WRITE, 8'h40, 16'h4444);
    @(posedge mclk) rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    check(sdo, 1'b0);
    check(sdo_oe_n, 1'b1);
    rd(8'h40, {FILL});
    wr(sea_pkg::OPC_WRITE, 8'h41, 16'h4141);
    rd(8'h41, {FILL});
  endtask

  initial begin
    rst = 1'b1;
    nv_init = 1'b1;
    supply_ok = 1'b1;
    error_cnt = 0;
    total_checks = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    nv_init <= 1'b0;
    repeat (8) @(posedge mclk);
    t_reset();
    t_fill();
    t_page();
    t_protect();
    t_lock();
    t_abort();
    t_wds();
    t_supply();
    t_allow();
    t_rst_mid();
    end_sim();
  end
  // tests need roughly a third of this span
  initial begin
    #600000;
    error_cnt++;
    $display("FAIL %0t watchdog expired", $time);
    end_sim();
  end
endmodule
